// [fsrp_pkg.sv]
// Constants, state codes and timing counts shared by both link ends.
// Assumes a 100 MHz core clock on each end.
// How it works
// - Opcode 5Ah, three address bytes, one dummy
// - Chip select high ends output at once
// - Host holds reset low ten microseconds minimum
// - Pin reset restores standby and volatile defaults
// - Reset during program or erase aborts it
// - Output floats, minimum activity while reset held
// - Host waits ten microseconds before selecting
// - Host recovery time depends on interrupted operation
// - Read or power-on reset needs 35 us
// - Power-up gives standby with latch cleared
// - Below supply threshold, logic held, commands ignored
// - Host waits supply settle delay before commands
// - Host keeps chip deselected during supply ramps
package fsrp_pkg;

  // Command framing
  localparam logic [7:0] OP_READ_PARAMS = 8'h5a;
  localparam int ADDR_BYTES = 3;
  localparam int DUMMY_BYTES = 1;
  localparam int BYTE_BITS = 8;
  localparam int CMD_BITS = (1 + ADDR_BYTES + DUMMY_BYTES) * BYTE_BITS;

  // Clock rate
  localparam int CLK_PERIOD_NS = 10;

  // Minimum times, in their own units
  localparam int RESET_LOW_PULSE_MIN_US = 10;
  localparam int RESET_RELEASE_TO_SELECT_US = 10;
  localparam int POWERON_RESET_RECOVERY_US = 35;
  localparam int RECOV_DECODE_US = 40;
  localparam int RECOV_READ_US = 35;
  localparam int RECOV_SECTOR_MS = 12;
  localparam int RECOV_BLOCK_MS = 25;
  localparam int RECOV_CHIP_MS = 100;
  localparam int RECOV_STATUS_MS = 40;

  // Least times, rounded up to whole cycles
  localparam int RESET_LOW_CYC =
    (RESET_LOW_PULSE_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RELEASE_CYC =
    (RESET_RELEASE_TO_SELECT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWERON_RECOV_CYC =
    (POWERON_RESET_RECOVERY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOV_DECODE_CYC =
    (RECOV_DECODE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOV_READ_CYC =
    (RECOV_READ_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOV_SECTOR_CYC =
    (RECOV_SECTOR_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOV_BLOCK_CYC =
    (RECOV_BLOCK_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOV_CHIP_CYC =
    (RECOV_CHIP_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOV_STATUS_CYC =
    (RECOV_STATUS_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // What a pin reset interrupted
  typedef enum logic [2:0] {
    CAUSE_READ = 3'h0,
    CAUSE_DECODE = 3'h1,
    CAUSE_SECTOR = 3'h2,
    CAUSE_BLOCK = 3'h3,
    CAUSE_CHIP = 3'h4,
    CAUSE_STATUS = 3'h5
  } fsrp_cause_e;

  // Device link states
  typedef enum logic [2:0] {
    LK_OPC = 3'h0,
    LK_ADDR = 3'h1,
    LK_DUMMY = 3'h2,
    LK_DATA = 3'h3,
    LK_IGNORE = 3'h4
  } fsrp_link_e;

  // Host states
  typedef enum logic [2:0] {
    H_PWR = 3'h0,
    H_PORREC = 3'h1,
    H_IDLE = 3'h2,
    H_RLOW = 3'h3,
    H_RWAIT = 3'h4,
    H_SHIFT = 3'h5,
    H_DATA = 3'h6,
    H_END = 3'h7
  } fsrp_host_e;

endpackage

// [fsrp_link_if.sv]
// Serial link between the flash host and the flash device.
// The host reads a released data-out wire as pulled high.
`timescale 1ns/1ps
interface fsrp_link_if;
  logic cs_n;
  logic sclk;
  logic si;
  logic so;
  logic so_oe;
  logic reset_n;

  // Flash device end
  modport dev (
    input cs_n,
    input sclk,
    input si,
    input reset_n,
    output so,
    output so_oe
  );

  // Host controller end
  modport host (
    output cs_n,
    output sclk,
    output si,
    output reset_n,
    input so,
    input so_oe
  );
endinterface

// [fsrp_device_end.sv]
// Flash device end: reset pin, supply gating, volatile state and the
// parameter read command.
// Core logic runs on clk_in; the shifter runs on the link clock, which
// only toggles inside frames.
`timescale 1ns/1ps
module fsrp_device_end
  import fsrp_pkg::*;
(
  // Core clock and power-on reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Link
  fsrp_link_if.dev lk,
  // Supply monitor, high while above write_inhibit_threshold
  input wire logic supply_ok_in,
  // Parameter table lookup, link clock domain
  output logic [23:0] param_addr_out,
  input wire logic [7:0] param_data_in,
  // Array control events, core clock domain
  input wire logic latch_set_in,
  input wire logic lock_set_in,
  input wire logic prog_set_in,
  input wire logic prog_done_in,
  // Volatile state and status
  output logic write_enable_latch_out,
  output logic write_in_progress_out,
  output logic lock_out,
  output logic abort_out,
  output logic standby_out,
  output logic low_activity_out
);

  // Core clock domain state
  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic sup_s1;
    logic sup_s2;
    logic held;
    logic we_latch;
    logic in_prog;
    logic lock;
    logic abort;
  } fsrp_core_s;

  // Link clock domain state
  typedef struct packed {
    logic en_s1;
    logic en_s2;
    fsrp_link_e st;
    logic [2:0] bitc;
    logic [7:0] sh;
    logic [1:0] nbytes;
    logic [23:0] addr;
    logic [7:0] obuf;
  } fsrp_lnk_s;

  fsrp_core_s c;
  fsrp_core_s next_c;
  fsrp_lnk_s l;
  fsrp_lnk_s next_l;
  logic hold;
  logic [7:0] byte_in;
  logic byte_done;

  // Core: pin and supply synchronisers, volatile bits
  always_comb begin
    next_c = c;
    next_c.rst_s1 = ~lk.reset_n;
    next_c.rst_s2 = c.rst_s1;
    next_c.sup_s1 = supply_ok_in;
    next_c.sup_s2 = c.sup_s1;
    // Low supply and reset pin share one hold path
    hold = c.rst_s2 | ~c.sup_s2;
    next_c.held = hold;
    // One pulse when a running program or erase is cut off
    next_c.abort = hold & c.in_prog;
    if (hold) begin
      // Standby defaults loaded on every cycle of the hold
      next_c.we_latch = 1'b0;
      next_c.in_prog = 1'b0;
      next_c.lock = 1'b0;
    end else begin
      if (lock_set_in) begin
        next_c.lock = 1'b1;
      end
      // Completion clears both; a set in the same cycle wins
      if (prog_done_in) begin
        next_c.in_prog = 1'b0;
        next_c.we_latch = 1'b0;
      end
      if (latch_set_in) begin
        next_c.we_latch = 1'b1;
      end
      if (prog_set_in) begin
        next_c.in_prog = 1'b1;
      end
    end
  end

  // Power-on reset loads the held state with the latch cleared; standby follows the supply sync
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      c <= '0;
      c.held <= 1'b1;
    end else begin
      c <= next_c;
    end
  end

  // Byte assembly from the serial input
  assign byte_in = {l.sh[6:0], lk.si};
  assign byte_done = (l.bitc == 3'h7);

  // Link: command decode and parameter streaming
  always_comb begin
    next_l = l;
    // Level crossing of the ready state into the link domain
    next_l.en_s1 = ~c.held;
    next_l.en_s2 = l.en_s1;
    next_l.sh = byte_in;
    next_l.bitc = l.bitc + 3'h1;
    case (l.st)
      LK_OPC: begin
        if (byte_done) begin
          // Commands are dropped while the core is held
          if (byte_in == OP_READ_PARAMS && l.en_s2) begin
            next_l.st = LK_ADDR;
          end else begin
            next_l.st = LK_IGNORE;
          end
          next_l.nbytes = 2'h0;
        end
      end
      LK_ADDR: begin
        if (byte_done) begin
          next_l.addr = {l.addr[15:0], byte_in};
          if (l.nbytes == 2'(ADDR_BYTES - 1)) begin
            next_l.st = LK_DUMMY;
          end else begin
            next_l.nbytes = l.nbytes + 2'h1;
          end
        end
      end
      LK_DUMMY: begin
        // First byte is loaded on the last dummy edge
        if (byte_done) begin
          next_l.st = LK_DATA;
          next_l.obuf = param_data_in;
          next_l.addr = l.addr + 24'h1;
        end
      end
      LK_DATA: begin
        next_l.obuf = {l.obuf[6:0], 1'b0};
        if (byte_done) begin
          // Streams on with no end of its own
          next_l.obuf = param_data_in;
          next_l.addr = l.addr + 24'h1;
        end
        // Reset or supply loss mid-frame kills the output
        if (!l.en_s2) begin
          next_l.st = LK_IGNORE;
        end
      end
      LK_IGNORE: begin
        next_l.st = LK_IGNORE;
      end
      default: begin
        next_l.st = LK_IGNORE;
      end
    endcase
  end

  // Deselect clears the shifter, since no edge follows the frame
  always_ff @(posedge lk.sclk or posedge lk.cs_n) begin
    if (lk.cs_n) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  // Output drive, dropped at once on deselect or hold
  assign lk.so = l.obuf[7];
  assign lk.so_oe = ~lk.cs_n & (l.st == LK_DATA) & l.en_s2
                  & ~c.held;
  assign param_addr_out = l.addr;

  // Status outputs, all from core flops
  assign write_enable_latch_out = c.we_latch;
  assign write_in_progress_out = c.in_prog;
  assign lock_out = c.lock;
  assign abort_out = c.abort;
  assign standby_out = ~c.held;
  assign low_activity_out = c.held;

endmodule

// [fsrp_host_end.sv]
// Host end: power-up sequencing, reset pulses with recovery waits, and
// parameter reads into a small FIFO.
// The host makes the link clock by dividing clk_in.
`timescale 1ns/1ps
module fsrp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Fill side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // Drain side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fsrp_fifo_s;

  fsrp_fifo_s f;
  fsrp_fifo_s next_f;
  logic wr;
  logic rd;

  // Pointer step with wrap at the depth
  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    step = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  assign in_ready_out = (f.cnt != (AW + 1)'(DEPTH));
  assign out_valid_out = (f.cnt != '0);
  assign out_data_out = f.mem[f.rp];
  assign wr = in_valid_in & in_ready_out;
  assign rd = out_valid_out & out_ready_in;

  // Storage and occupancy
  always_comb begin
    next_f = f;
    if (wr) begin
      next_f.mem[f.wp] = in_data_in;
      next_f.wp = step(f.wp);
    end
    if (rd) begin
      next_f.rp = step(f.rp);
    end
    next_f.cnt = f.cnt + (AW + 1)'(wr) - (AW + 1)'(rd);
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      f <= '0;
    end else begin
      f <= next_f;
    end
  end
endmodule

module fsrp_host_end
  import fsrp_pkg::*;
#(
  parameter int HALF_CYC = 4,
  parameter int FIFO_DEPTH = 4,
  parameter int SUPPLY_SETTLE_CYC = 1000,
  parameter int RECOV_SECTOR = RECOV_SECTOR_CYC,
  parameter int RECOV_BLOCK = RECOV_BLOCK_CYC,
  parameter int RECOV_CHIP = RECOV_CHIP_CYC,
  parameter int RECOV_STATUS = RECOV_STATUS_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Link
  fsrp_link_if.host lk,
  // Supply at its minimum level
  input wire logic power_good_in,
  // Requests
  input wire logic reset_req_in,
  input wire fsrp_cause_e reset_cause_in,
  input wire logic read_req_in,
  input wire logic [23:0] read_addr_in,
  input wire logic [15:0] read_len_in,
  // Parameter bytes out
  output logic [7:0] data_out,
  output logic data_valid_out,
  input wire logic data_ready_in,
  // Status
  output logic ready_out
);
  localparam logic [7:0] PH_HALF = 8'(HALF_CYC - 1);
  localparam logic [7:0] PH_LAST = 8'(2 * HALF_CYC - 1);

  typedef struct packed {
    fsrp_host_e st;
    logic so_s1;
    logic so_s2;
    logic [23:0] cnt;
    logic [23:0] wait_cyc;
    logic [7:0] ph;
    logic [5:0] bits;
    logic [CMD_BITS-1:0] sh;
    logic [15:0] rem;
    logic [7:0] rbyte;
    logic push;
    logic cs_n;
    logic sclk;
    logic si;
    logic rst_n;
  } fsrp_host_s;

  fsrp_host_s h;
  fsrp_host_s next_h;
  logic fifo_rdy;
  logic stall;

  // Recovery per interrupted operation, never under release-to-select
  function automatic logic [23:0] recov(input fsrp_cause_e cause);
    int v;
    case (cause)
      CAUSE_READ: v = RECOV_READ_CYC;
      CAUSE_DECODE: v = RECOV_DECODE_CYC;
      CAUSE_SECTOR: v = RECOV_SECTOR;
      CAUSE_BLOCK: v = RECOV_BLOCK;
      CAUSE_CHIP: v = RECOV_CHIP;
      CAUSE_STATUS: v = RECOV_STATUS;
      default: v = RECOV_CHIP;
    endcase
    if (v < RELEASE_CYC) begin
      v = RELEASE_CYC;
    end
    recov = 24'(v - 1);
  endfunction

  // Hold the clock low before a byte until the FIFO has room
  assign stall = (h.st == H_DATA) && (h.bits == 6'h0) && (h.ph == 8'h0)
               && (!fifo_rdy || h.push);

  always_comb begin
    next_h = h;
    next_h.so_s1 = lk.so_oe ? lk.so : 1'b1;  // Released line idles high
    next_h.so_s2 = h.so_s1;
    next_h.push = 1'b0;
    case (h.st)
      H_PWR: begin
        // Settle delay after supply reaches its minimum
        if (h.cnt == 24'h0) begin
          next_h.st = H_PORREC;
          next_h.cnt = 24'(POWERON_RECOV_CYC - 1);
        end else begin
          next_h.cnt = h.cnt - 24'h1;
        end
      end
      H_PORREC: begin
        if (h.cnt == 24'h0) begin
          next_h.st = H_IDLE;
        end else begin
          next_h.cnt = h.cnt - 24'h1;
        end
      end
      H_IDLE: begin
        if (reset_req_in) begin
          next_h.st = H_RLOW;
          next_h.rst_n = 1'b0;
          next_h.cnt = 24'(RESET_LOW_CYC - 1);
          next_h.wait_cyc = recov(reset_cause_in);
        end else if (read_req_in) begin
          next_h.st = H_SHIFT;
          next_h.cs_n = 1'b0;
          next_h.sh = {OP_READ_PARAMS, read_addr_in, 8'h00};
          next_h.rem = read_len_in - 16'h1;
          next_h.bits = 6'h0;
          next_h.ph = 8'h0;
        end
      end
      H_RLOW: begin
        if (h.cnt == 24'h0) begin
          next_h.rst_n = 1'b1;
          next_h.cnt = h.wait_cyc;
          next_h.st = H_RWAIT;
        end else begin
          next_h.cnt = h.cnt - 24'h1;
        end
      end
      H_RWAIT: begin
        if (h.cnt == 24'h0) begin
          next_h.st = H_IDLE;
        end else begin
          next_h.cnt = h.cnt - 24'h1;
        end
      end
      H_SHIFT, H_DATA: begin
        if (!stall) begin
          next_h.ph = (h.ph == PH_LAST) ? 8'h0 : h.ph + 8'h1;
          if (h.ph == 8'h0) begin
            next_h.si = (h.st == H_SHIFT) ? h.sh[CMD_BITS-1] : 1'b0;
          end
          // Rising edge; the synced data bit is taken here
          if (h.ph == PH_HALF) begin
            next_h.sclk = 1'b1;
            next_h.bits = h.bits + 6'h1;
            next_h.sh = {h.sh[CMD_BITS-2:0], 1'b0};
            next_h.rbyte = {h.rbyte[6:0], h.so_s2};
          end
          if (h.ph == PH_LAST) begin
            next_h.sclk = 1'b0;
            if (h.st == H_SHIFT && h.bits == 6'(CMD_BITS)) begin
              next_h.st = H_DATA;
              next_h.bits = 6'h0;
            end else if (h.st == H_DATA && h.bits == 6'(BYTE_BITS)) begin
              next_h.push = 1'b1;
              next_h.bits = 6'h0;
              if (h.rem == 16'h0) begin
                next_h.st = H_END;
              end else begin
                next_h.rem = h.rem - 16'h1;
              end
            end
          end
        end
      end
      H_END: begin
        // Deselect ends the stream
        next_h.cs_n = 1'b1;
        next_h.st = H_IDLE;
      end
      default: begin
        next_h.st = H_PWR;
      end
    endcase
    // Any supply dip forces deselect and a fresh power-up wait
    if (!power_good_in) begin
      next_h.st = H_PWR;
      next_h.cs_n = 1'b1;
      next_h.sclk = 1'b0;
      next_h.rst_n = 1'b1;
      next_h.cnt = 24'(SUPPLY_SETTLE_CYC - 1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      h <= '0;
      h.st <= H_PWR;
      h.cnt <= 24'(SUPPLY_SETTLE_CYC - 1);
      h.cs_n <= 1'b1;
      h.rst_n <= 1'b1;
    end else begin
      h <= next_h;
    end
  end

  // Received bytes; the reader can stall the link through the FIFO
  fsrp_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .in_valid_in(h.push),
    .in_data_in(h.rbyte),
    .in_ready_out(fifo_rdy),
    .out_valid_out(data_valid_out),
    .out_data_out(data_out),
    .out_ready_in(data_ready_in)
  );

  assign lk.cs_n = h.cs_n;
  assign lk.sclk = h.sclk;
  assign lk.si = h.si;
  assign lk.reset_n = h.rst_n;
  assign ready_out = (h.st == H_IDLE);

endmodule

// [fsrp_props.sv]
// Wire-level checks on the flash link between the host and device ends.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/1ps
module fsrp_props
  import fsrp_pkg::*;
(
  // Core clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Link wires
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  input wire logic so_oe,
  input wire logic reset_n
);
  logic [5:0] rise_cnt;
  logic [7:0] shift;
  logic [15:0] low_cnt;
  logic [15:0] high_cnt;

  // Rises and serial input bits of the open frame, saturating count
  always_ff @(posedge clk_in) begin
    if (srst_in || cs_n) begin
      rise_cnt <= 6'h00;
      shift <= 8'h00;
    end else if ($rose(sclk)) begin
      rise_cnt <= (rise_cnt == 6'h3f) ? rise_cnt : rise_cnt + 6'h01;
      shift <= {shift[6:0], si};
    end
  end

  // Pin low width and time since release; the release count saturates to avoid wrap
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      low_cnt <= 16'h0000;
      high_cnt <= 16'h0000;
    end else begin
      low_cnt <= reset_n ? 16'h0000 : low_cnt + 16'h0001;
      high_cnt <= !reset_n ? 16'h0000 :
                  (&high_cnt ? high_cnt : high_cnt + 16'h0001);
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  // Frame steps: opcode closed, dummy closed, pin dropped and quiet
  sequence s_opcode_done;
    $rose(sclk) && !cs_n && rise_cnt == 6'd7;
  endsequence
  sequence s_dummy_done;
    $rose(sclk) && !cs_n && rise_cnt == 6'd39;
  endsequence
  sequence s_pin_drop;
    $fell(reset_n);
  endsequence
  sequence s_quiet8;
    (!reset_n && cs_n && !so_oe) [*8];
  endsequence

  a_opcode_sent:
    assert property (s_opcode_done |=> shift == OP_READ_PARAMS)
    else $error("opcode bits on serial input are wrong");
  a_dummy_sent:
    assert property (s_dummy_done |=> shift == 8'h00)
    else $error("dummy byte bits are wrong");
  a_quiet_in_cmd:
    assert property (!cs_n && rise_cnt < 6'd39 |-> !so_oe)
    else $error("device drives output during the command");
  a_drive_data:
    assert property (!cs_n && reset_n && rise_cnt > 6'd40 |-> so_oe)
    else $error("device stopped driving inside the data stream");
  a_oe_deselect:
    assert property (cs_n |-> !so_oe)
    else $error("output driven while deselected");
  a_oe_reset_pin:
    assert property (!reset_n |-> !so_oe)
    else $error("output driven while reset pin is low");
  a_no_select_reset:
    assert property (!reset_n |-> cs_n)
    else $error("device selected while reset pin is low");
  a_pin_low_width:
    assert property ($rose(reset_n) |-> low_cnt >= 16'(RESET_LOW_CYC))
    else $error("reset pin pulse too short");
  a_select_gap:
    assert property ($fell(cs_n) |-> high_cnt >= 16'(RELEASE_CYC))
    else $error("select too soon after reset release");
  a_clock_in_frame:
    assert property ($rose(sclk) |-> !cs_n)
    else $error("link clock toggles outside a frame");
  a_reset_entry:
    assert property (s_pin_drop |-> s_quiet8)
    else $error("link not quiet after reset pin drop");
endmodule

// [flash_reset_and_param_read_tb.sv]
// Bench for the flash reset and parameter read link, both ends joined.
// Assumes package, interface, design ends and checker compile first.
`timescale 1ns/1ps
module flash_reset_and_param_read_tb;
  import fsrp_pkg::*;
  localparam int SETTLE = 20;
  localparam int RP = 2000; // Short erase recoveries keep the run brief
  localparam int FIFO_D = 4;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic supply_ok_in = 1'b1;
  logic power_good_in = 1'b0;
  logic reset_req_in = 1'b0;
  logic read_req_in = 1'b0;
  logic data_ready_in = 1'b0;
  logic latch_set_in = 1'b0;
  logic lock_set_in = 1'b0;
  logic prog_set_in = 1'b0;
  fsrp_cause_e reset_cause_in = CAUSE_READ;
  logic [23:0] read_addr_in = 24'h000000;
  logic [15:0] read_len_in = 16'h0001;
  logic [23:0] param_addr_out;
  logic [7:0] param_data_in, data_out;
  logic data_valid_out, ready_out, we_latch, in_prog, lock, abort;
  logic standby, low_act;
  logic [39:0] cmd_bits = 40'h0;
  logic [5:0] frame_rises = 6'h00;
  int failures = 0;
  int samples_checked = 0;

  // Parameter table stand-in mixing the low address bytes
  function automatic logic [7:0] pbyte(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5c;
  endfunction
  assign param_data_in = pbyte(param_addr_out);

  // Core clock, 100 MHz
  always #5 clk_in = ~clk_in;

  fsrp_link_if lk_if();
  fsrp_device_end fsrp_device_end_inst (
    .clk_in(clk_in), .srst_in(srst_in), .lk(lk_if),
    .supply_ok_in(supply_ok_in), .param_addr_out(param_addr_out),
    .param_data_in(param_data_in), .latch_set_in(latch_set_in),
    .lock_set_in(lock_set_in), .prog_set_in(prog_set_in),
    .prog_done_in(1'b0), .write_enable_latch_out(we_latch),
    .write_in_progress_out(in_prog), .lock_out(lock), .abort_out(abort),
    .standby_out(standby), .low_activity_out(low_act));
  fsrp_host_end #(.FIFO_DEPTH(FIFO_D), .SUPPLY_SETTLE_CYC(SETTLE),
    .RECOV_SECTOR(RP), .RECOV_BLOCK(RP), .RECOV_CHIP(RP),
    .RECOV_STATUS(RP)) fsrp_host_end_inst (
    .clk_in(clk_in), .srst_in(srst_in), .lk(lk_if),
    .power_good_in(power_good_in), .reset_req_in(reset_req_in),
    .reset_cause_in(reset_cause_in), .read_req_in(read_req_in),
    .read_addr_in(read_addr_in), .read_len_in(read_len_in),
    .data_out(data_out), .data_valid_out(data_valid_out),
    .data_ready_in(data_ready_in), .ready_out(ready_out));
  fsrp_props fsrp_props_inst (
    .clk_in(clk_in), .srst_in(srst_in), .cs_n(lk_if.cs_n),
    .sclk(lk_if.sclk), .si(lk_if.si), .so_oe(lk_if.so_oe),
    .reset_n(lk_if.reset_n));

  // Sniffer for the first 40 command bits of each frame
  always @(posedge lk_if.sclk or posedge lk_if.cs_n) begin
    if (lk_if.cs_n) begin
      frame_rises <= 6'h00;
    end else if (frame_rises < 6'd40) begin
      frame_rises <= frame_rises + 6'h01;
      cmd_bits <= {cmd_bits[38:0], lk_if.si};
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic check(input string what, input logic [23:0] seen,
                       input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One-cycle user events into the device core
  task automatic pulse(input logic w, input logic l, input logic p);
    latch_set_in = w;
    lock_set_in = l;
    prog_set_in = p;
    tick(1);
    latch_set_in = 1'b0;
    lock_set_in = 1'b0;
    prog_set_in = 1'b0;
    tick(2);
  endtask

  // Power-up: device in standby at once, host waits settle and recovery
  task automatic t_power();
    int n;
    tick(5);
    check("standby", 24'(standby), 24'h1);
    check("low activity", 24'(low_act), 24'h0);
    check("latch", 24'(we_latch), 24'h0);
    tick(45);
    power_good_in = 1'b1;
    tick(SETTLE + POWERON_RECOV_CYC - 5);
    check("early ready", 24'(ready_out), 24'h0);
    for (n = 0; n < 60 && ready_out !== 1'b1; n++)
      tick(1);
    check("ready", 24'(ready_out), 24'h1);
    check("deselected", 24'(lk_if.cs_n), 24'h1);
  endtask

  // Parameter read; a stalled drain fills the FIFO and parks the clock
  task automatic t_read(input logic [23:0] addr, input int len,
                        input int stall);
    int n;
    read_addr_in = addr;
    read_len_in = 16'(len);
    read_req_in = 1'b1;
    tick(1);
    read_req_in = 1'b0;
    tick(stall);
    if (len > FIFO_D) begin
      check("frame held", 24'(lk_if.cs_n), 24'h0);
      check("still driving", 24'(lk_if.so_oe), 24'h1);
    end
    // Drain stays open; each byte is judged before the edge that pops it
    data_ready_in = 1'b1;
    for (int i = 0; i < len; i++) begin
      for (n = 0; n < 600 && data_valid_out !== 1'b1; n++)
        tick(1);
      check("byte", 24'(data_out), 24'(pbyte(addr + 24'(i))));
      tick(1);
    end
    data_ready_in = 1'b0;
    for (n = 0; n < 200 && ready_out !== 1'b1; n++)
      tick(1);
    check("op addr", cmd_bits[39:16], {8'h5a, addr[23:8]});
    check("addr dummy", 24'(cmd_bits[15:0]), 24'(addr[7:0]) << 8);
    check("end select", 24'(lk_if.cs_n), 24'h1);
    check("end drive", 24'(lk_if.so_oe), 24'h0);
  endtask

  // Supply below threshold: core held, user events ignored
  task automatic t_supply();
    supply_ok_in = 1'b0;
    tick(6);
    check("held standby", 24'(standby), 24'h0);
    pulse(1'b1, 1'b1, 1'b0);
    check("latch ignored", 24'({we_latch, lock}), 24'h0);
    supply_ok_in = 1'b1;
    tick(6);
    pulse(1'b1, 1'b0, 1'b0);
    check("latch after", 24'(we_latch), 24'h1);
  endtask

  // Pin reset over one interrupted operation
  task automatic t_reset(input fsrp_cause_e cause, input int rec,
                         input logic busy);
    int n;
    logic ab;
    pulse(1'b1, 1'b1, busy);
    check("busy flag", 24'(in_prog), 24'(busy));
    reset_cause_in = cause;
    reset_req_in = 1'b1;
    tick(1);
    reset_req_in = 1'b0;
    ab = 1'b0;
    for (n = 0; n < 12; n++) begin
      tick(1);
      ab = ab | (abort === 1'b1);
    end
    check("abort", 24'(ab), 24'(busy));
    pulse(1'b1, 1'b0, 1'b0);
    check("volatile", 24'({we_latch, in_prog, lock}), 24'h0);
    check("quiet", 24'({standby, low_act}), 24'h1);
    check("quiet out", 24'(lk_if.so_oe), 24'h0);
    for (n = 0; n < 1100 && lk_if.reset_n !== 1'b1; n++)
      tick(1);
    for (n = 0; n < 6000 && ready_out !== 1'b1; n++)
      tick(1);
    check("ready back", 24'(ready_out), 24'h1);
    check("recovery", 24'(n + 2 >= rec), 24'h1);
    check("standby back", 24'({standby, low_act}), 24'h2);
  endtask

  // Main sequence
  initial begin
    tick(12);
    srst_in = 1'b0;
    t_power();
    t_read(24'h0000fe, 6, 800);
    t_read(24'h000030, 1, 0);
    t_supply();
    t_reset(CAUSE_READ, RECOV_READ_CYC, 1'b0);
    // A read right after a pin reset exercises the release-to-select gap
    t_read(24'h000100, 1, 0);
    t_reset(CAUSE_DECODE, RECOV_DECODE_CYC, 1'b0);
    t_reset(CAUSE_SECTOR, RP, 1'b1);
    t_reset(CAUSE_BLOCK, RP, 1'b1);
    t_reset(CAUSE_CHIP, RP, 1'b1);
    t_reset(CAUSE_STATUS, RP, 1'b1);
    finish_test();
  end

  // Watchdog, well beyond the expected 27000 cycles
  initial begin
    repeat (60000) @(posedge clk_in);
    failures++;
    finish_test();
  end
endmodule
